/* File: rtl/irs_top.sv */
// region sequencer: apb registers, entry list, capture sequencing and flash window
`timescale 1ns/1ps
`include "irs_regs.svh"
// How it works
// [R1] list holds up to 32 entries
// [R2] list repeats while sequencer stays enabled
// [R3] per-image, per-list or free-run triggering
// [R4] entries run in order, wrap to first
// [R5] each entry supplies region, timing, runs, flash
// [R6] stored column plus one is first column
// [R7] delay spaces successive exposure starts
// [R8] globals stored but frozen while enabled
// [R9] multipliers scale by variant time base
// [R10] software keeps exposure and delay in range
// [R11] zero-run entries skipped without capture
// [R12] flash enable bit gates flash output
// [R13] flash window is exposure minus height
// [R14] software keeps exposure above height plus window
// [R15] software keeps delay at least height
// [R16] shared flash offset, oversized offset blocks flash
// [R17] mode zero disables, default after reset
// [R18] per-image mode ignores delay, starts at edge
// [R19] per-list mode stops after list, awaits edge
// [R20] region, runs, flash 16 bits; timing 32; code counts only the low 8 bits of runs
// [R21] all-zero list captures nothing, still disableable
// [R22] edges during a capture are ignored
module irs_top
  import irs_pkg::*;
#(
  parameter int DEPTH = 32,
  parameter int VARIANT = 0
)
(
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // trigger pin
  input wire logic external_frame_trigger,
  // capture control
  output irs_cap_type cap,
  output logic cap_start,
  output logic cap_expose,
  output logic flash_trigger,
  output logic seq_active
);
  localparam int IW = $clog2(DEPTH);
  localparam real TB_US = (VARIANT == 1) ? `IRS_TB1_US :
                          (VARIANT == 2) ? `IRS_TB2_US : `IRS_TB0_US;
  localparam int TB_CYC = int'(TB_US * 1000.0 / `IRS_CLK_NS);

  typedef struct packed {
    irs_raw_type [DEPTH-1:0] mem;
    logic [6:0][31:0] glb;
    logic [6:0][31:0] act;
    logic [15:0] fofs;
    irs_mode_type mode;
    irs_mode_type run_mode;
    logic [IW:0] len;
    logic [IW-1:0] sel;
    irs_state_type st;
    logic [IW-1:0] idx;
    logic [7:0] run;
    logic list_go;
    logic trig_q;
    logic [31:0] el;
    irs_cap_type cap;
    logic cap_start;
    logic expose;
    logic flash;
    logic active;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } irs_seq_state_type;

  irs_seq_state_type r, rn;
  irs_entry_type cur;
  logic rst_n;
  logic trig_s;
  logic tick;
  logic tclr;
  logic ten;
  logic tedge;
  logic wrap;
  logic last_run;
  logic [2:0] k;
  logic hit;
  logic wr;
  logic go;
  logic nxt;
  logic fok;
  logic [31:0] rd;
  logic [31:0] msk;
  logic signed [33:0] els;
  logic signed [33:0] fo;
  logic signed [33:0] hs;

  // reset is released through two flops; ce must not hold it
  irs_sync #(.W(1)) u_rst (
    .clk(clk),
    .rst_n(rst_b),
    .ce(1'b1),
    .d(1'b1),
    .q(rst_n)
  );

  irs_sync #(.W(1)) u_trig (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(external_frame_trigger),
    .q(trig_s)
  );

  irs_tick #(.DIV(TB_CYC)) u_tick ( // [R9]
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .en(ten),
    .clr(tclr),
    .tick(tick)
  );

  assign cur = irs_unpack(r.mem[r.idx]);
  assign wrap = ({1'b0, r.idx} == r.len - 1'b1);
  assign last_run = ({1'b0, r.run} + 9'h1) >= {1'b0, cur.runs[7:0]};
  assign tedge = trig_s & ~r.trig_q;
  assign ten = (r.st == S_EXP) || (r.st == S_GAP);

  always_comb
  begin
    rn = r;
    rn.cap_start = 1'b0;
    rn.pready = 1'b0;
    rn.trig_q = trig_s;
    k = paddr[4:2];
    hit = 1'b1;
    rd = 32'h0000_0000;
    go = 1'b0;
    nxt = 1'b0;
    tclr = 1'b0;
    // only exposure and delay are wide; other entry fields keep 16 bits
    msk = (k == `IRS_F_EXP || k == `IRS_F_DLY) ? 32'hffff_ffff : `IRS_NARROW_MASK; // [R20]
    wr = psel && penable && r.pready && pwrite;
    // register decode
    if (paddr[7:5] == `IRS_ENT_GRP)
      rd = r.mem[r.sel][k];
    else if (paddr[7:5] == `IRS_GLB_GRP)
      rd = (k == `IRS_FOFS_IDX) ? {16'h0000, r.fofs} : r.glb[k];
    else
    begin
      case ({paddr[7:2], 2'b00})
        `IRS_CTRL_OFS: rd[`IRS_MODE_LSB +: 2] = r.mode;
        `IRS_STAT_OFS:
        begin
          rd[`IRS_STAT_IDX_LSB +: IW] = r.idx;
          rd[`IRS_STAT_RUN_LSB +: 8] = r.run;
          rd[`IRS_STAT_ACT_BIT] = r.active;
          rd[`IRS_STAT_ST_LSB +: 6] = r.st;
        end
        `IRS_LEN_OFS: rd[IW:0] = r.len;
        `IRS_SEL_OFS: rd[IW-1:0] = r.sel;
        default: hit = 1'b0;
      endcase
    end
    // zero-wait answer: ready is loaded in the setup cycle and is high in the first access cycle
    if (psel && !penable && !r.pready)
    begin
      rn.pready = 1'b1;
      rn.pslverr = !hit;
      rn.prdata = rd;
    end
    if (wr && hit)
    begin
      if (paddr[7:5] == `IRS_ENT_GRP)
        rn.mem[r.sel][k] = pwdata & msk; // [R1] [R20]
      else if (paddr[7:5] == `IRS_GLB_GRP)
      begin
        if (k == `IRS_FOFS_IDX)
          rn.fofs = pwdata[15:0];
        else
          rn.glb[k] = pwdata; // [R8]
      end
      else
      begin
        case ({paddr[7:2], 2'b00})
          `IRS_CTRL_OFS: rn.mode = irs_mode_type'(pwdata[`IRS_MODE_LSB +: 2]);
          `IRS_LEN_OFS:
          begin
            // out-of-range lengths are dropped rather than clipped
            if (pwdata != 32'h0 && pwdata <= 32'(DEPTH))
              rn.len = pwdata[IW:0];
          end
          `IRS_SEL_OFS: rn.sel = pwdata[IW-1:0];
          default: rn.sel = r.sel;
        endcase
      end
    end
    // flash window, shifted by the shared offset
    els = $signed({2'b00, r.el});
    fo = 34'(signed'(r.fofs));
    hs = $signed({18'h00000, cur.height});
    fok = (hs != 34'sh0) && (fo <= hs - 34'sh1) && (-fo <= hs - 34'sh1); // [R16]
    rn.flash = ten && cur.flash[0] && fok && (els >= hs + fo) &&
               (els < $signed({2'b00, cur.exp}) + fo); // [R12] [R13]
    // sequencer
    if (r.mode == IRS_OFF || r.mode != r.run_mode)
    begin
      rn.st = S_IDLE; // [R17]
      rn.run_mode = r.mode;
      rn.idx = '0;
      rn.run = 8'h00;
      rn.list_go = 1'b0;
      rn.expose = 1'b0;
      rn.flash = 1'b0;
      rn.active = 1'b0;
      if (r.mode == IRS_OFF)
      begin
        rn.act = r.glb; // [R8]
        rn.cap = '{rn.act[0][15:0], rn.act[1][15:0], rn.act[2][15:0],
                   rn.act[3][15:0], rn.act[4], rn.act[5], rn.act[6][15:0]};
      end
    end
    else
    begin
      case (r.st)
        S_IDLE:
        begin
          rn.st = S_SEEK;
          rn.active = 1'b1;
        end
        S_SEEK:
        begin
          if (cur.runs[7:0] == 8'h00)
            nxt = 1'b1; // [R11] [R21]
          else if (r.run_mode == IRS_FREE || (r.run_mode == IRS_PER_LIST && r.list_go))
            go = 1'b1; // [R3]
          else
            rn.st = S_WAIT; // [R3]
        end
        S_WAIT:
        begin
          if (tedge)
          begin
            rn.list_go = (r.run_mode == IRS_PER_LIST); // [R19]
            go = 1'b1; // [R18]
          end
        end
        S_EXP:
        begin
          // trigger edges are not looked at here
          if (tick)
          begin
            rn.el = r.el + 32'h1;
            if (rn.el >= cur.exp)
            begin
              rn.expose = 1'b0;
              rn.st = (r.run_mode == IRS_PER_IMG) ? S_ADV : S_GAP; // [R18] [R22]
            end
          end
        end
        S_GAP:
        begin
          if (r.el >= cur.dly)
            rn.st = S_ADV; // [R7]
          else if (tick)
            rn.el = r.el + 32'h1; // [R7]
        end
        S_ADV:
        begin
          rn.st = S_SEEK;
          if (last_run)
            nxt = 1'b1;
          else
            rn.run = r.run + 8'h1;
        end
        default: rn.st = S_IDLE;
      endcase
      if (nxt)
      begin
        rn.run = 8'h00;
        rn.idx = wrap ? '0 : r.idx + 1'b1; // [R4] [R2]
        if (wrap && r.run_mode == IRS_PER_LIST)
          rn.list_go = 1'b0; // [R19]
      end
      if (go)
      begin
        rn.st = S_EXP;
        rn.el = 32'h0;
        rn.expose = 1'b1;
        rn.cap_start = 1'b1;
        tclr = 1'b1;
        rn.cap = '{cur.col + 16'h1, cur.width, cur.line, cur.height,
                   cur.exp, cur.dly, r.act[6][15:0]}; // [R5] [R6]
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      r <= '0;
      r.st <= S_IDLE;
      r.mode <= irs_mode_type'(`IRS_MODE_RST);
      r.run_mode <= irs_mode_type'(`IRS_MODE_RST);
      r.len <= (IW+1)'(DEPTH);
      r.sel <= IW'(`IRS_SEL_RST);
      r.glb <= {7{`IRS_GLB_RST}};
      r.act <= {7{`IRS_GLB_RST}};
      r.fofs <= `IRS_FOFS_RST;
    end
    else if (ce)
      r <= rn;
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign cap = r.cap;
  assign cap_start = r.cap_start;
  assign cap_expose = r.expose;
  assign flash_trigger = r.flash;
  assign seq_active = r.active;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  property p_off_idle;
    (ce && r.mode == IRS_OFF) |=> (r.st == S_IDLE && !cap_expose && !seq_active);
  endproperty
  a_off_idle: assert property (p_off_idle) else $error("sequencer runs while off"); // [R17]

  property p_trig_start;
    (ce && r.st == S_WAIT && r.run_mode == IRS_PER_IMG && r.mode == r.run_mode && tedge)
      |=> (r.st == S_EXP && cap_start && cap_expose);
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("edge did not start exposure"); // [R18]

  property p_hold_idx;
    (ce && r.st == S_EXP && r.mode == r.run_mode) |=> ($stable(r.idx) && $stable(r.run));
  endproperty
  a_hold_idx: assert property (p_hold_idx) else $error("position moved during exposure"); // [R22]

  property p_skip;
    (ce && r.st == S_SEEK && cur.runs[7:0] == 8'h00) |=> !cap_start;
  endproperty
  a_skip: assert property (p_skip) else $error("zero-run entry captured"); // [R11]

  property p_gap;
    (ce && r.st == S_GAP && r.mode == r.run_mode && r.el < cur.dly) |=> r.st == S_GAP;
  endproperty
  a_gap: assert property (p_gap) else $error("delay cut short"); // [R7]

  property p_frozen;
    (ce && r.mode != IRS_OFF) |=> $stable(r.act);
  endproperty
  a_frozen: assert property (p_frozen) else $error("globals applied while enabled"); // [R8]

  property p_col;
    (ce && go) |=> (cap.col - 16'h1) == $past(cur.col);
  endproperty
  a_col: assert property (p_col) else $error("start column not stored plus one"); // [R6]

  property p_order;
    (ce && r.st == S_ADV && r.mode == r.run_mode && last_run && !wrap)
      |=> r.idx == $past(r.idx) + 1'b1;
  endproperty
  a_order: assert property (p_order) else $error("entry order broken"); // [R4]

  property p_list_end;
    (ce && r.st == S_ADV && r.run_mode == IRS_PER_LIST && r.mode == r.run_mode && last_run && wrap)
      |=> !r.list_go ##1 (r.st != S_EXP);
  endproperty
  a_list_end: assert property (p_list_end) else $error("list ran on without edge"); // [R19]

  property p_flash;
    flash_trigger |-> $past(cur.flash[0]);
  endproperty
  a_flash: assert property (p_flash) else $error("flash on for disabled entry"); // [R12]

  c_img: cover property (r.st == S_WAIT ##1 r.st == S_EXP);
  c_list_done: cover property (r.run_mode == IRS_PER_LIST && r.st == S_WAIT && !r.list_go);
  c_free_wrap: cover property (r.run_mode == IRS_FREE && r.st == S_ADV && wrap && last_run);
endmodule

/* File: rtl/irs_regs.svh */
// register offsets, field positions, reset values and timing of the region sequencer
`ifndef IRS_REGS_SVH
`define IRS_REGS_SVH
`define IRS_CTRL_OFS 8'h00
`define IRS_STAT_OFS 8'h04
`define IRS_LEN_OFS 8'h08
`define IRS_SEL_OFS 8'h0c
`define IRS_ENT_GRP 3'h1
`define IRS_GLB_GRP 3'h2
`define IRS_FOFS_IDX 3'h7
`define IRS_F_EXP 3'h4
`define IRS_F_DLY 3'h5
`define IRS_MODE_LSB 0
`define IRS_STAT_IDX_LSB 0
`define IRS_STAT_RUN_LSB 8
`define IRS_STAT_ACT_BIT 16
`define IRS_STAT_ST_LSB 24
`define IRS_MODE_RST 2'h0
`define IRS_SEL_RST 8'h00
`define IRS_GLB_RST 32'h0000_0000
`define IRS_FOFS_RST 16'h0000
`define IRS_NARROW_MASK 32'h0000_ffff
`define IRS_CLK_NS 100.0
`define IRS_TB0_US 4.56
`define IRS_TB1_US 3.445
`define IRS_TB2_US 2.764
`endif

/* File: rtl/irs_pkg.sv */
// types shared by the region sequencer
package irs_pkg;
  typedef enum logic [1:0] {
    IRS_OFF = 2'h0,
    IRS_PER_IMG = 2'h1,
    IRS_PER_LIST = 2'h2,
    IRS_FREE = 2'h3
  } irs_mode_type;
  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_SEEK = 6'h02,
    S_WAIT = 6'h04,
    S_EXP = 6'h08,
    S_GAP = 6'h10,
    S_ADV = 6'h20
  } irs_state_type;
  typedef struct packed {
    logic [15:0] col;
    logic [15:0] width;
    logic [15:0] line;
    logic [15:0] height;
    logic [31:0] exposure;
    logic [31:0] period;
    logic [15:0] cache;
  } irs_cap_type;
  typedef struct packed {
    logic [15:0] col;
    logic [15:0] width;
    logic [15:0] line;
    logic [15:0] height;
    logic [31:0] exp;
    logic [31:0] dly;
    logic [15:0] runs;
    logic [15:0] flash;
  } irs_entry_type;
  typedef logic [7:0][31:0] irs_raw_type;
  function automatic irs_entry_type irs_unpack(irs_raw_type w);
    irs_entry_type e;
    e = '{w[0][15:0], w[1][15:0], w[2][15:0], w[3][15:0], w[4], w[5], w[6][15:0], w[7][15:0]};
    return e;
  endfunction
endpackage

/* File: rtl/irs_sync.sv */
// two-flop synchroniser, also used to release the reset
`timescale 1ns/1ps
module irs_sync
  import irs_pkg::*;
#(
  parameter int W = 1
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } irs_sync_state_type;
  irs_sync_state_type r, rn;
  always_comb
  begin
    rn.s1 = d;
    rn.s2 = r.s1;
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else if (ce)
      r <= rn;
  end
  assign q = r.s2;
endmodule

/* File: rtl/irs_tick.sv */
// time-base tick: one pulse every DIV enabled cycles
`timescale 1ns/1ps
module irs_tick
  import irs_pkg::*;
#(
  parameter int DIV = 46
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // control
  input wire logic en,
  input wire logic clr,
  output logic tick
);
  localparam int W = (DIV > 1) ? $clog2(DIV) : 1;
  typedef struct packed {
    logic [W-1:0] cnt;
    logic tick;
  } irs_tick_state_type;
  irs_tick_state_type r, rn;
  always_comb
  begin
    rn = r;
    rn.tick = 1'b0;
    if (clr)
      rn.cnt = '0;
    else if (en)
    begin
      if (r.cnt == W'(DIV - 1))
      begin
        rn.cnt = '0;
        rn.tick = 1'b1;
      end
      else
        rn.cnt = r.cnt + 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      r <= '0;
    else if (ce)
      r <= rn;
  end
  assign tick = r.tick;
endmodule

/* File: tb/irs_trig_model.sv */
// model of the external frame trigger source
`timescale 1ns/1ps
module irs_trig_model
(
  // clock
  input wire logic clk,
  // request from the bench
  input wire logic go,
  input wire logic [7:0] hold,
  // trigger pin
  output logic external_frame_trigger
);
  logic [7:0] cnt_reg = 8'h00;
  // pin idles low; only the rising edge carries meaning
  always_ff @(posedge clk)
  begin
    if (go)
      cnt_reg <= hold;
    else if (cnt_reg != 8'h00)
      cnt_reg <= cnt_reg - 8'h01;
  end
  assign external_frame_trigger = (cnt_reg != 8'h00);
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the region sequencer
`timescale 1ns/1ps
`include "irs_regs.svh"
module testbench;
  import irs_pkg::*;
  logic clk, rst_b, psel, penable, pwrite, pready, pslverr, go, er;
  logic [7:0] paddr, hold;
  logic [31:0] pwdata, prdata, rv;
  irs_cap_type cap;
  logic cap_start, cap_expose, flash_trigger, seq_active, trig;
  int errors, checked, fcnt, fbad, cyc, ecnt;
  int ts[$];
  logic [15:0] cols[$];
  irs_top #(.DEPTH(32), .VARIANT(0)) irs_top_inst (.clk(clk), .rst_b(rst_b), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .external_frame_trigger(trig),
    .cap(cap), .cap_start(cap_start), .cap_expose(cap_expose),
    .flash_trigger(flash_trigger), .seq_active(seq_active));
  irs_trig_model irs_trig_model_inst (.clk(clk), .go(go), .hold(hold),
    .external_frame_trigger(trig));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // capture log; flash only ever expected on the column-1 entry
  always @(posedge clk)
  begin
    cyc++;
    if (cap_start === 1'b1)
    begin
      cols.push_back(cap.col);
      ts.push_back(cyc);
    end
    if (cap_expose === 1'b1)
      ecnt++;
    if (flash_trigger === 1'b1)
    begin
      fcnt++;
      if (cap.col !== 16'h0001)
        fbad++;
    end
  end
  task automatic summarize();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rv = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a);
    apb(a, 1'b0, 32'h0000_0000);
  endtask
  // exposure 2 and delay 3 keep within range; delay is not below height 1
  // exposure 2 covers height 1 plus a window of one time base
  task automatic ent(input logic [4:0] i, input logic [15:0] c, input logic [7:0] r,
                     input logic f);
    wr(`IRS_SEL_OFS, {27'h0, i});
    wr(8'h20, {16'h0, c});
    wr(8'h24, 32'h1234_0010);
    wr(8'h28, 32'h0000_0000);
    wr(8'h2c, 32'h0000_0001);
    wr(8'h30, 32'h0000_0002);
    wr(8'h34, 32'h0000_0003);
    wr(8'h38, {24'h0, r});
    wr(8'h3c, {31'h0, f});
  endtask
  // margin so the sequencer has settled into its wait state
  task automatic fire();
    repeat (2) @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  task automatic seq3(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
    chk({16'h0, cols[0]}, {16'h0, a});
    chk({16'h0, cols[1]}, {16'h0, b});
    chk({16'h0, cols[2]}, {16'h0, c});
  endtask
  initial
  begin
    #2000000;
    errors++;
    summarize();
  end
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    go = 1'b0;
    hold = 8'h04;
    rst_b = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    rd(`IRS_CTRL_OFS);
    chk(rv, 32'h0000_0000);
    wr(`IRS_LEN_OFS, 32'h0000_0000);
    rd(`IRS_LEN_OFS);
    chk(rv, 32'h0000_0020);
    rd(8'h60);
    chk({31'h0, er}, 32'h0000_0001);
    ent(5'h00, 16'h0000, 8'h01, 1'b1);
    ent(5'h01, 16'h0005, 8'h00, 1'b1);
    ent(5'h02, 16'h0009, 8'h02, 1'b0);
    rd(8'h24);
    chk(rv, 32'h0000_0010);
    wr(`IRS_LEN_OFS, 32'h0000_0003);
    // free run, global column written mid-run
    fcnt = 0;
    fbad = 0;
    cols.delete();
    ts.delete();
    wr(`IRS_CTRL_OFS, 32'h0000_0003);
    wr(8'h40, 32'h0000_0055);
    repeat (800) @(posedge clk);
    chk(32'(cols.size() >= 4), 32'h0000_0001);
    seq3(16'h0001, 16'h000a, 16'h000a);
    chk({16'h0, cols[3]}, 32'h0000_0001);
    chk(32'(fbad), 32'h0000_0000);
    chk(32'(fcnt > 0), 32'h0000_0001);
    // delay 3 times 46 cycles between starts, a few cycles of stepping on top
    chk(32'(ts[2] - ts[1] >= 138 && ts[2] - ts[1] <= 146), 32'h0000_0001);
    wr(`IRS_CTRL_OFS, 32'h0000_0000);
    repeat (5) @(posedge clk);
    chk({16'h0, cap.col}, 32'h0000_0055);
    chk({31'h0, seq_active}, 32'h0000_0000);
    // one image per edge; an edge mid-exposure is dropped
    cols.delete();
    wr(`IRS_CTRL_OFS, 32'h0000_0001);
    fcnt = 0;
    ecnt = 0;
    fire();
    repeat (10) @(posedge clk);
    chk(32'(cols.size()), 32'h0000_0001);
    chk({31'h0, cap_expose}, 32'h0000_0001);
    chk({cap.width, cap.height}, 32'h0010_0001);
    chk(cap.exposure, 32'h0000_0002);
    chk(cap.period, 32'h0000_0003);
    repeat (10) @(posedge clk);
    fire();
    repeat (400) @(posedge clk);
    chk(32'(cols.size()), 32'h0000_0001);
    chk({31'h0, cap_expose}, 32'h0000_0000);
    // exposure 2 times 46 cycles, plus a cycle or two of latency
    chk(32'(ecnt >= 92 && ecnt <= 94), 32'h0000_0001);
    // window is exposure minus height, one time base
    chk(32'(fcnt >= 46 && fcnt <= 47), 32'h0000_0001);
    fire();
    repeat (400) @(posedge clk);
    chk(32'(cols.size()), 32'h0000_0002);
    chk({16'h0, cols[1]}, 32'h0000_000a);
    // whole list per edge, with an offset too large for height 1
    wr(8'h5c, 32'h0000_0005);
    fcnt = 0;
    cols.delete();
    wr(`IRS_CTRL_OFS, 32'h0000_0002);
    fire();
    repeat (1500) @(posedge clk);
    chk(32'(cols.size()), 32'h0000_0003);
    seq3(16'h0001, 16'h000a, 16'h000a);
    chk(32'(fcnt), 32'h0000_0000);
    fire();
    repeat (1500) @(posedge clk);
    chk(32'(cols.size()), 32'h0000_0006);
    // list with no runs anywhere
    wr(`IRS_CTRL_OFS, 32'h0000_0000);
    wr(`IRS_SEL_OFS, 32'h0000_0000);
    wr(8'h38, 32'h0000_0000);
    wr(`IRS_SEL_OFS, 32'h0000_0002);
    wr(8'h38, 32'h0000_0000);
    cols.delete();
    wr(`IRS_CTRL_OFS, 32'h0000_0003);
    repeat (500) @(posedge clk);
    chk(32'(cols.size()), 32'h0000_0000);
    wr(`IRS_CTRL_OFS, 32'h0000_0000);
    repeat (3) @(posedge clk);
    chk({31'h0, seq_active}, 32'h0000_0000);
    summarize();
  end
endmodule
